// ---- pkg/dps_pkg.sv ----
// Constants and types shared by the drive protection supervisor
// Summary of operation
// R1 - Raise overload prevention whenever output current exceeds inverter rated current.
// R2 - Selector code 7 drives that output as alarm during inverter overload trip.
// R3 - Loss criterion: 0 off, 1 less-than comparison, 2 below-minimum comparison.
// R4 - Check reference loss only for voltage, current, summed or communication sources.
// R5 - Voltage source, criterion 1: loss when input below half its minimum.
// R6 - Summed source, criterion 2: loss when either input below its minimum.
// R7 - Apply fallback mode only after loss persists for the wait time; the code holds FREQ_CMD from the first cycle of raw loss, before the wait.
// R8 - Fallback: 0 hold last frequency, 1 free-run cutoff, 2 decelerate to stop.
// R9 - Selector code 11 drives that output on confirmed reference loss.
// R10 - A fault cannot be cleared while its cause is still present.
// R11 - Trip on overcurrent above 200 percent of rated current.
// R12 - Trip on ground fault current above fixed internal threshold.
// R13 - Trip on inverter overload when above 150 percent for one minute.
// R14 - Trip on overload when 150 percent persists beyond one minute.
// R15 - Trip on heat sink overheat.
// R16 - Trip when link capacitor is due for replacement.
// R17 - Trip when one or more output phases are open.
// R18 - Trip on link voltage above 400 V.
// R19 - Trip on link voltage below 180 V.
// R20 - Thermal model of motor heating trips on motor overload.
// R21 - Show parameter-save fault when nonvolatile write fails.
// R22 - Emergency stop cuts output at once; release with run resumes.
// R23 - Trips latch cutoff and code until clear; fixed priority picks code.
// R24 - Wait timer counts tenths, restarts on valid reference, fires on match.
package dps_pkg;
    localparam int CLK_PERIOD_NS = 40;
    localparam int TENTH_SEC_NS = 100_000_000;
    localparam int TICK_CYCLES_DEF = TENTH_SEC_NS / CLK_PERIOD_NS;
    localparam int OL_TIME_S = 60;
    localparam logic [9:0] OL_TICKS = 10'(OL_TIME_S * 10);
    localparam logic [9:0] OV_LIMIT_V = 10'd400;
    localparam logic [9:0] UV_LIMIT_V = 10'd180;
    localparam logic [11:0] GND_LIMIT = 12'h0c8;
    localparam logic [7:0] HS_LIMIT = 8'h64;
    localparam logic [11:0] PHASE_MIN = 12'h010;
    localparam logic [19:0] THERM_LIMIT = 20'h80000;
    localparam logic [19:0] THERM_LEAK = 20'h00010;
    localparam logic [4:0] SEL_OL_ALARM = 5'h07;
    localparam logic [4:0] SEL_REF_LOSS = 5'h0b;
    localparam logic [3:0] SRC_V1 = 4'h3;
    localparam logic [3:0] SRC_CUR = 4'h5;
    localparam logic [3:0] SRC_SUM = 4'h6;
    localparam logic [3:0] SRC_COMM = 4'h7;
    localparam logic [1:0] CRIT_OFF = 2'h0;
    localparam logic [1:0] CRIT_LT_HALF = 2'h1;
    localparam logic [1:0] CRIT_BELOW = 2'h2;
    localparam logic [1:0] FB_CONTINUE = 2'h0;
    localparam logic [1:0] FB_FREE_RUN = 2'h1;
    localparam logic [1:0] FB_DECEL = 2'h2;
    localparam logic [15:0] FREQ_RESET = 16'h0000;
    typedef enum logic [3:0] {
        FC_NONE = 4'h0, FC_OVERCURRENT = 4'h1, FC_GROUND = 4'h2, FC_INV_OVERLOAD = 4'h3,
        FC_OVERLOAD = 4'h4, FC_OVERHEAT = 4'h5, FC_CAP_WEAR = 4'h6, FC_PHASE_LOSS = 4'h7,
        FC_OVERVOLT = 4'h8, FC_UNDERVOLT = 4'h9, FC_THERMAL = 4'ha, FC_PARAM_SAVE = 4'hb
    } dps_fault_t;
    typedef enum logic [1:0] {ST_NORMAL = 2'b00, ST_TRIPPED = 2'b01} dps_state_t;
    typedef struct packed {
        logic [11:0] out_current;
        logic [11:0] rated_current;
        logic [2:0][11:0] phase_current;
        logic [11:0] ground_current;
        logic [9:0] link_voltage;
        logic [7:0] heatsink_temp;
    } dps_meas_t;
    typedef struct packed {
        logic [3:0] source;
        logic [1:0] ref_loss_criterion;
        logic [1:0] ref_loss_fallback_mode;
        logic [7:0] ref_loss_wait_time;
        logic [11:0] voltage_min;
        logic [11:0] current_min;
    } dps_ref_cfg_t;
endpackage

// ---- rtl/dps_supervisor.sv ----
// Protective supervision: trips, fault latch and reference-loss handling
`timescale 1ns/10ps
`default_nettype none
module dps_supervisor
    import dps_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF
)(
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RESET,
    // Measurements and status
    input wire dps_meas_t MEAS,
    input wire logic CAP_REPLACE_DUE,
    input wire logic PARAM_SAVE_FAIL,
    // Frequency reference
    input wire dps_ref_cfg_t REF_CFG,
    input wire logic [11:0] VOLTAGE_REF_INPUT,
    input wire logic [11:0] CURRENT_REF_INPUT,
    input wire logic COMM_REF_VALID,
    input wire logic [15:0] FREQ_REF,
    // Output selectors
    input wire logic [4:0] TRANSISTOR_OUTPUT_SELECT,
    input wire logic [4:0] RELAY_OUTPUT_SELECT,
    // Sequence
    input wire logic RUN_CMD,
    input wire logic EMERGENCY_STOP,
    input wire logic FAULT_CLEAR,
    // Drive control
    output logic OUTPUT_CUTOFF,
    output logic RUN_ENABLE,
    output logic DECEL_STOP,
    output logic [15:0] FREQ_CMD,
    output logic OL_PREVENT,
    // Status
    output logic REF_LOSS,
    output logic OPEN_COLLECTOR_OUTPUT,
    output logic FAULT_RELAY_OUTPUT,
    output logic FAULT_ACTIVE,
    output dps_fault_t FAULT_CODE
);
    logic [21:0] tick_cnt, next_tick_cnt;
    logic tick;
    logic [9:0] ol_cnt, next_ol_cnt;
    logic [19:0] therm, next_therm;
    logic [7:0] wait_cnt, next_wait_cnt;
    logic next_confirmed;
    logic [15:0] next_freq;
    dps_state_t state, next_state;
    dps_fault_t code, next_code, first;
    logic [11:1] cause;
    logic [2:0] open_phase;
    logic [1:0][4:0] sel;
    logic [1:0] next_alarm;
    logic over_rated, over200, at150, v_low, i_low, raw_loss, chk;
    logic next_cutoff, next_decel, trip_cut, inv_ol_trip;
    logic [12:0] cur_x2;
    logic [13:0] cur_x2w, rated_x3;
    logic [20:0] therm_sum;
    logic [7:0] wait_cfg;

    assign cur_x2 = {MEAS.out_current, 1'b0};
    assign cur_x2w = {1'b0, cur_x2};
    assign rated_x3 = {2'b00, MEAS.rated_current} + {1'b0, MEAS.rated_current, 1'b0};
    assign over_rated = MEAS.out_current > MEAS.rated_current;
    assign over200 = {1'b0, MEAS.out_current} > {MEAS.rated_current, 1'b0};
    assign at150 = cur_x2w >= rated_x3;
    assign tick = tick_cnt == 22'(TICK_CYCLES - 1);
    assign wait_cfg = REF_CFG.ref_loss_wait_time;

    // Phase counts as open when its current is below PHASE_MIN; the trip also needs output current at PHASE_MIN or more
    for (genvar p = 0; p < 3; p++)
    begin : g_phase
        assign open_phase[p] = MEAS.phase_current[p] < PHASE_MIN;
    end

    assign cause[FC_OVERCURRENT] = over200; // R11
    assign cause[FC_GROUND] = MEAS.ground_current > GND_LIMIT; // R12
    assign cause[FC_INV_OVERLOAD] = ol_cnt >= OL_TICKS && cur_x2w > rated_x3; // R13
    assign cause[FC_OVERLOAD] = ol_cnt > OL_TICKS; // R14
    assign cause[FC_OVERHEAT] = MEAS.heatsink_temp > HS_LIMIT; // R15
    assign cause[FC_CAP_WEAR] = CAP_REPLACE_DUE; // R16
    assign cause[FC_PHASE_LOSS] = |open_phase && MEAS.out_current >= PHASE_MIN; // R17
    assign cause[FC_OVERVOLT] = MEAS.link_voltage > OV_LIMIT_V; // R18
    assign cause[FC_UNDERVOLT] = MEAS.link_voltage < UV_LIMIT_V; // R19
    assign cause[FC_THERMAL] = therm >= THERM_LIMIT; // R20
    assign cause[FC_PARAM_SAVE] = PARAM_SAVE_FAIL; // R21

    // Reference-loss detection
    always_comb
    begin
        v_low = 1'b0;
        i_low = 1'b0;
        raw_loss = 1'b0;
        chk = REF_CFG.ref_loss_criterion == CRIT_LT_HALF || REF_CFG.ref_loss_criterion == CRIT_BELOW; // R3
        case (REF_CFG.ref_loss_criterion)
            CRIT_LT_HALF:
            begin
                v_low = VOLTAGE_REF_INPUT < {1'b0, REF_CFG.voltage_min[11:1]}; // R5
                i_low = CURRENT_REF_INPUT < {1'b0, REF_CFG.current_min[11:1]};
            end
            CRIT_BELOW:
            begin
                v_low = VOLTAGE_REF_INPUT < REF_CFG.voltage_min; // R6
                i_low = CURRENT_REF_INPUT < REF_CFG.current_min;
            end
            default:
            begin
                v_low = 1'b0;
                i_low = 1'b0;
            end
        endcase
        case (REF_CFG.source) // R4
            SRC_V1: raw_loss = v_low;
            SRC_CUR: raw_loss = i_low;
            SRC_SUM: raw_loss = v_low || i_low; // R6
            SRC_COMM: raw_loss = chk && !COMM_REF_VALID;
            default: raw_loss = 1'b0;
        endcase
    end

    // Timers: tenth-second tick, overload time, thermal model, loss wait
    always_comb
    begin
        next_tick_cnt = tick ? 22'h000000 : tick_cnt + 22'h000001;
        next_ol_cnt = ol_cnt;
        if (!at150)
            next_ol_cnt = 10'h000;
        else if (tick && ol_cnt <= OL_TICKS)
            next_ol_cnt = ol_cnt + 10'h001; // R13 R14
        therm_sum = {1'b0, therm} + {9'h000, MEAS.out_current - MEAS.rated_current};
        next_therm = therm;
        if (tick && over_rated)
            next_therm = therm_sum[20] ? 20'hfffff : therm_sum[19:0]; // R20
        else if (tick)
            next_therm = therm > THERM_LEAK ? therm - THERM_LEAK : 20'h00000;
        next_wait_cnt = wait_cnt;
        if (!raw_loss)
            next_wait_cnt = 8'h00; // R24
        else if (tick && wait_cnt != wait_cfg)
            next_wait_cnt = wait_cnt + 8'h01; // R24
        next_confirmed = raw_loss && wait_cnt == wait_cfg; // R7 R24
        // Last valid frequency is kept through a loss
        next_freq = raw_loss ? FREQ_CMD : FREQ_REF; // R8
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RESET)
        begin
            tick_cnt <= 22'h000000;
            ol_cnt <= 10'h000;
            therm <= 20'h00000;
            wait_cnt <= 8'h00;
            FREQ_CMD <= FREQ_RESET;
        end
        else
        begin
            tick_cnt <= next_tick_cnt;
            ol_cnt <= next_ol_cnt;
            therm <= next_therm;
            wait_cnt <= next_wait_cnt;
            FREQ_CMD <= next_freq;
        end
    end

    // Fault latch; lowest code wins when several causes coexist
    always_comb
    begin
        first = FC_NONE;
        for (int i = 11; i >= 1; i--)
        begin
            if (cause[i])
                first = dps_fault_t'(4'(i)); // R23
        end
        next_state = state;
        next_code = code;
        case (state)
            ST_NORMAL:
            begin
                if (first != FC_NONE)
                begin
                    next_state = ST_TRIPPED; // R23
                    next_code = first;
                end
            end
            ST_TRIPPED:
            begin
                if (first != FC_NONE && first < code)
                    next_code = first;
                else if (FAULT_CLEAR && first == FC_NONE)
                begin
                    next_state = ST_NORMAL; // R10
                    next_code = FC_NONE;
                end
            end
            default:
            begin
                next_state = ST_NORMAL;
                next_code = FC_NONE;
            end
        endcase
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RESET)
        begin
            state <= ST_NORMAL;
            code <= FC_NONE;
        end
        else
        begin
            state <= next_state;
            code <= next_code;
        end
    end

    // Output drive; all outputs are registered (OL_PREVENT from over_rated, the rest from next-state) so they lag causes by one edge
    assign sel[0] = TRANSISTOR_OUTPUT_SELECT;
    assign sel[1] = RELAY_OUTPUT_SELECT;
    assign inv_ol_trip = next_state == ST_TRIPPED && next_code == FC_INV_OVERLOAD;
    for (genvar g = 0; g < 2; g++)
    begin : g_sel
        assign next_alarm[g] = (sel[g] == SEL_OL_ALARM && inv_ol_trip) // R2
            || (sel[g] == SEL_REF_LOSS && next_confirmed); // R9
    end

    always_comb
    begin
        // Save failure is display only; the stage keeps running
        trip_cut = next_state == ST_TRIPPED && next_code != FC_PARAM_SAVE; // R23
        next_cutoff = EMERGENCY_STOP || trip_cut
            || (next_confirmed && REF_CFG.ref_loss_fallback_mode == FB_FREE_RUN); // R22 R8
        next_decel = next_confirmed && REF_CFG.ref_loss_fallback_mode == FB_DECEL; // R8
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RESET)
        begin
            OUTPUT_CUTOFF <= 1'b1;
            RUN_ENABLE <= 1'b0;
            DECEL_STOP <= 1'b0;
            OL_PREVENT <= 1'b0;
            REF_LOSS <= 1'b0;
            OPEN_COLLECTOR_OUTPUT <= 1'b0;
            FAULT_RELAY_OUTPUT <= 1'b0;
            FAULT_ACTIVE <= 1'b0;
            FAULT_CODE <= FC_NONE;
        end
        else
        begin
            OUTPUT_CUTOFF <= next_cutoff;
            RUN_ENABLE <= RUN_CMD && !next_cutoff; // R22
            DECEL_STOP <= next_decel;
            OL_PREVENT <= over_rated; // R1
            REF_LOSS <= next_confirmed;
            OPEN_COLLECTOR_OUTPUT <= next_alarm[0];
            FAULT_RELAY_OUTPUT <= next_alarm[1];
            FAULT_ACTIVE <= next_state == ST_TRIPPED;
            FAULT_CODE <= next_code;
        end
    end

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RESET);

    property p_prevent;
        over_rated |=> OL_PREVENT;
    endproperty
    a_prevent: assert property (p_prevent) else $error("overload prevention missed"); // R1
    property p_overcurrent;
        over200 |=> OUTPUT_CUTOFF && FAULT_ACTIVE && FAULT_CODE == FC_OVERCURRENT;
    endproperty
    a_overcurrent: assert property (p_overcurrent) else $error("overcurrent not tripped"); // R11
    property p_overvolt;
        MEAS.link_voltage > OV_LIMIT_V |=> OUTPUT_CUTOFF && FAULT_CODE != FC_NONE;
    endproperty
    a_overvolt: assert property (p_overvolt) else $error("overvoltage not tripped"); // R18
    property p_undervolt;
        MEAS.link_voltage < UV_LIMIT_V |=> OUTPUT_CUTOFF && FAULT_ACTIVE;
    endproperty
    a_undervolt: assert property (p_undervolt) else $error("undervoltage not tripped"); // R19
    property p_estop;
        EMERGENCY_STOP |=> OUTPUT_CUTOFF && !RUN_ENABLE;
    endproperty
    a_estop: assert property (p_estop) else $error("emergency stop ignored"); // R22
    property p_noclear;
        FAULT_ACTIVE && cause != 11'h000 |=> FAULT_ACTIVE ##0 FAULT_CODE != FC_NONE;
    endproperty
    a_noclear: assert property (p_noclear) else $error("fault cleared with cause present"); // R10
    property p_restart;
        !raw_loss |=> wait_cnt == 8'h00 && !REF_LOSS;
    endproperty
    a_restart: assert property (p_restart) else $error("wait timer not restarted"); // R24
    property p_wait;
        $rose(REF_LOSS) |-> $past(wait_cnt) == $past(wait_cfg) && $past(raw_loss);
    endproperty
    a_wait: assert property (p_wait) else $error("loss confirmed before wait time"); // R7
    property p_loss_out;
        REF_LOSS && $past(TRANSISTOR_OUTPUT_SELECT) == SEL_REF_LOSS |-> OPEN_COLLECTOR_OUTPUT;
    endproperty
    a_loss_out: assert property (p_loss_out) else $error("loss output not driven"); // R9
    property p_inv_ol;
        ol_cnt == OL_TICKS && cur_x2w > rated_x3 |=> FAULT_ACTIVE && OUTPUT_CUTOFF;
    endproperty
    a_inv_ol: assert property (p_inv_ol) else $error("inverter overload not tripped"); // R13
    property p_thermal;
        therm >= THERM_LIMIT |=> FAULT_ACTIVE && OUTPUT_CUTOFF;
    endproperty
    a_thermal: assert property (p_thermal) else $error("thermal model trip missed"); // R20
endmodule
`default_nettype wire

// ---- bench/dps_stage_model.sv ----
// Power stage model: turns bench load settings into the measurements
`timescale 1ns/10ps
`default_nettype none
module dps_stage_model
    import dps_pkg::*;
(
    // Drive side
    input wire logic OUTPUT_CUTOFF,
    // Load settings
    input wire logic [11:0] load_current,
    input wire logic [11:0] leak_current,
    input wire logic [9:0] bus_voltage,
    input wire logic [7:0] sink_temp,
    input wire logic open_phase,
    // Measurements
    output var dps_meas_t meas
);
    logic [11:0] i_out;
    // No current flows once the stage is off, so the causes of current trips clear themselves
    assign i_out = OUTPUT_CUTOFF ? 12'h000 : load_current;
    assign meas = '{out_current: i_out, rated_current: 12'h064,
        phase_current: {i_out, i_out, open_phase ? 12'h000 : i_out},
        ground_current: OUTPUT_CUTOFF ? 12'h000 : leak_current,
        link_voltage: bus_voltage, heatsink_temp: sink_temp};
endmodule
`default_nettype wire

// ---- bench/drive_protection_supervisor_tb.sv ----
// Self-checking bench for the drive protection supervisor
`timescale 1ns/10ps
`default_nettype none
module drive_protection_supervisor_tb;
    import dps_pkg::*;
    localparam int TICK = 4;
    logic ref_clk, reset, cap_due, save_fail, comm_ok, run_cmd, estop, clr, open_ph;
    logic [11:0] cur, gnd, vin, iin;
    logic [9:0] volt;
    logic [7:0] temp;
    logic [15:0] fref, fcmd;
    logic [4:0] tsel, rsel;
    logic [1:0] mode;
    logic cutoff, run_en, decel, ol_prev, ref_loss, oc_out, relay_out, f_act;
    dps_ref_cfg_t cfg;
    dps_meas_t meas;
    dps_fault_t fcode;
    int fail_count, check_count, seed, i;
    logic [3:0] codes [8] = '{4'h1, 4'h2, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hb};

    dps_stage_model stage_u (.OUTPUT_CUTOFF(cutoff), .load_current(cur), .leak_current(gnd), .bus_voltage(volt),
        .sink_temp(temp), .open_phase(open_ph), .meas(meas));
    dps_supervisor #(.TICK_CYCLES(TICK)) dut_u (.REF_CLK(ref_clk), .RESET(reset), .MEAS(meas),
        .CAP_REPLACE_DUE(cap_due), .PARAM_SAVE_FAIL(save_fail), .REF_CFG(cfg), .VOLTAGE_REF_INPUT(vin),
        .CURRENT_REF_INPUT(iin), .COMM_REF_VALID(comm_ok), .FREQ_REF(fref), .TRANSISTOR_OUTPUT_SELECT(tsel),
        .RELAY_OUTPUT_SELECT(rsel), .RUN_CMD(run_cmd), .EMERGENCY_STOP(estop), .FAULT_CLEAR(clr),
        .OUTPUT_CUTOFF(cutoff), .RUN_ENABLE(run_en), .DECEL_STOP(decel), .FREQ_CMD(fcmd), .OL_PREVENT(ol_prev),
        .REF_LOSS(ref_loss), .OPEN_COLLECTOR_OUTPUT(oc_out), .FAULT_RELAY_OUTPUT(relay_out),
        .FAULT_ACTIVE(f_act), .FAULT_CODE(fcode));

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
            fail_count++;
        end
    endtask
    // Inputs move 2 ns after the edge, when registered outputs have settled
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Healthy plant with a random light load
    task automatic nominal();
        cur = 12'h010 + 12'($unsigned($random(seed)) % 80);
        gnd = 12'h000;
        volt = 10'd300;
        temp = 8'h28;
        cap_due = 1'b0;
        save_fail = 1'b0;
        open_ph = 1'b0;
    endtask
    task automatic wait_fault(input int bound);
        for (int k = 0; k < bound && f_act !== 1'b1; k++)
            cyc(1);
        if (f_act !== 1'b1)
        begin
            fail_count++;
            final_report();
        end
    endtask
    task automatic clear_fault();
        nominal();
        clr = 1'b1;
        cyc(2);
        clr = 1'b0;
        check("cleared code", 16'(fcode), 16'h0000);
    endtask
    task automatic run_loss(input logic [3:0] src, input logic [1:0] crit, input logic [11:0] v, input logic [11:0] c,
        input logic ok, input logic exp);
        logic [15:0] f0;
        f0 = 16'($random(seed));
        fref = f0;
        cfg.source = src;
        cfg.ref_loss_criterion = crit;
        cfg.ref_loss_fallback_mode = mode;
        cyc(2);
        vin = v;
        iin = c;
        comm_ok = ok;
        cyc(1);
        fref = ~f0;
        cyc(1);
        check("loss early", ref_loss, 1'b0);
        cyc(14);
        check("loss", ref_loss, exp);
        check("mo loss", oc_out, exp);
        check("relay loss", relay_out, exp);
        check("decel", decel, exp && mode == FB_DECEL);
        check("free run", cutoff, exp && mode == FB_FREE_RUN);
        check("freq hold", fcmd, exp ? f0 : ~f0);
        vin = 12'hfff;
        iin = 12'hfff;
        comm_ok = 1'b1;
        cyc(3);
        check("loss gone", ref_loss, 1'b0);
        mode = (mode == 2'h2) ? 2'h0 : mode + 2'h1;
    endtask

    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    initial
    begin
        seed = 29;
        fail_count = 0;
        check_count = 0;
        reset = 1'b1;
        nominal();
        run_cmd = 1'b1;
        estop = 1'b0;
        clr = 1'b0;
        comm_ok = 1'b1;
        vin = 12'hfff;
        iin = 12'hfff;
        fref = 16'h0000;
        tsel = 5'h00;
        rsel = 5'h00;
        mode = FB_CONTINUE;
        cfg = '{source: 4'h0, ref_loss_criterion: CRIT_LT_HALF, ref_loss_fallback_mode: FB_CONTINUE,
            ref_loss_wait_time: 8'd2, voltage_min: 12'h400, current_min: 12'h100};
        cyc(12);
        check("reset cutoff", cutoff, 1'b1);
        check("reset code", 16'(fcode), 16'h0000);
        reset = 1'b0;
        cyc(2);
        check("run", run_en, 1'b1);
        // Overcurrent, ground, heat sink and both link voltage levels exactly at their limits must not trip
        cur = 12'h0c8;
        gnd = 12'h0c8;
        temp = 8'h64;
        volt = 10'd400;
        cyc(3);
        volt = 10'd180;
        cyc(3);
        check("no trip", f_act, 1'b0);
        for (i = 0; i < 8; i++)
        begin
            nominal();
            cyc(1);
            case (i)
                0: cur = 12'h0c9;
                1: gnd = 12'h0c9;
                2: temp = 8'h65;
                3: cap_due = 1'b1;
                4: open_ph = 1'b1;
                5: volt = 10'd401;
                6: volt = 10'd179;
                default: save_fail = 1'b1;
            endcase
            cyc(1);
            check("trip code", 16'(fcode), 16'(codes[i]));
            check("trip cutoff", cutoff, i != 7);
            clear_fault();
        end
        volt = 10'd401;
        cyc(2);
        clr = 1'b1;
        cyc(3);
        check("held fault", 16'(fcode), 16'h0008);
        clear_fault();
        cap_due = 1'b1;
        cyc(2);
        volt = 10'd401;
        cyc(2);
        check("no replace", 16'(fcode), 16'h0006);
        temp = 8'h65;
        cyc(2);
        check("preempt", 16'(fcode), 16'h0005);
        clear_fault();
        estop = 1'b1;
        cyc(1);
        check("estop cutoff", cutoff, 1'b1);
        check("estop run", run_en, 1'b0);
        estop = 1'b0;
        cyc(1);
        check("resume", cutoff, 1'b0);
        check("resume run", run_en, 1'b1);
        tsel = SEL_OL_ALARM;
        rsel = SEL_OL_ALARM;
        cur = 12'h064;
        cyc(2);
        check("ol at rated", ol_prev, 1'b0);
        cur = 12'h097;
        cyc(2);
        check("ol above", ol_prev, 1'b1);
        cyc(2380);
        check("early inv ol", f_act, 1'b0);
        wait_fault(60);
        check("inv ol code", 16'(fcode), 16'h0003);
        check("alarm mo", oc_out, 1'b1);
        check("alarm relay", relay_out, 1'b1);
        clear_fault();
        cur = 12'h096;
        cyc(2390);
        check("early ol", f_act, 1'b0);
        wait_fault(60);
        check("ol code", 16'(fcode), 16'h0004);
        clear_fault();
        tsel = SEL_REF_LOSS;
        rsel = SEL_REF_LOSS;
        run_loss(SRC_V1, CRIT_LT_HALF, 12'h1ff, 12'hfff, 1'b1, 1'b1);
        run_loss(SRC_V1, CRIT_LT_HALF, 12'h200, 12'hfff, 1'b1, 1'b0);
        run_loss(SRC_V1, CRIT_OFF, 12'h000, 12'hfff, 1'b1, 1'b0);
        run_loss(SRC_SUM, CRIT_BELOW, 12'hfff, 12'h0ff, 1'b1, 1'b1);
        run_loss(SRC_SUM, CRIT_BELOW, 12'h3ff, 12'hfff, 1'b1, 1'b1);
        run_loss(SRC_CUR, CRIT_BELOW, 12'hfff, 12'h0ff, 1'b1, 1'b1);
        run_loss(SRC_COMM, CRIT_LT_HALF, 12'hfff, 12'hfff, 1'b0, 1'b1);
        run_loss(4'h0, CRIT_LT_HALF, 12'h000, 12'h000, 1'b0, 1'b0);
        run_loss(SRC_SUM, 2'h3, 12'h000, 12'h000, 1'b1, 1'b0);
        // Just under the overload level, so only the thermal model can trip
        cur = 12'h095;
        wait_fault(45000);
        check("thermal code", 16'(fcode), 16'h000a);
        check("thermal cutoff", cutoff, 1'b1);
        final_report();
    end
endmodule
`default_nettype wire
